// file: asc_cfg.svh
// constants of the setup and configuration register bank
// assumes an 8-bit register address and 24-bit register data
//
// Notes on behaviour
// - each gain word is 24-bit read/write, loaded at power-on with a per-part trim.
// - gain word is replaced by a system full-scale calibration or a host write.
// - each offset word is 24-bit read/write and powers on at 0x800000.
// - offset word is replaced by internal/system zero-scale calibration or a host write.
// - conversion mode register at 0x01 picks mode, calibration and clock source.
// - reference source is chosen per setup, not in the conversion mode register.
// - interface mode register at 0x02 holds readback options, resets to 0x0000.
// - eight setups exist; any number of slots may share one setup.
// - top bit of each channel slot register enables that slot's input pair.
// - sequencer visits enabled slots in ascending order, then wraps to lowest.
// - setup config 0 at 0x20 resets to 0x1000 with polarity, buffers, burnout, reference.
// - bipolar gives offset binary with negative inputs; unipolar gives straight binary.
// - reference select sits in bits 5:4 and defaults to the primary external pair.
// - each channel slot register has a setup select choosing one of eight setups.
`ifndef ASC_CFG_SVH
`define ASC_CFG_SVH

// ==========================================================
// register addresses
`define ASC_ADDR_MODE 8'h01
`define ASC_ADDR_SERIAL_INTERFACE_MODE_REG 8'h02
`define ASC_ADDR_SLOT0 8'h10
`define ASC_ADDR_SETUP0 8'h20
`define ASC_ADDR_FILT0 8'h28
`define ASC_ADDR_OFFSET_COEFF_REG0 8'h30
`define ASC_ADDR_GAIN_COEFF_REG0 8'h38

// ==========================================================
// reset values and writable-bit masks
`define ASC_MODE_RST 16'h2000
`define ASC_MODE_MASK 16'h677C
`define ASC_SERIAL_INTERFACE_MODE_REG_RST 16'h0000
`define ASC_SERIAL_INTERFACE_MODE_REG_MASK 16'h19ED
`define ASC_SETUP_RST 16'h1000
`define ASC_SETUP_MASK 16'h1FB0
`define ASC_FILT_RST 16'h0500
`define ASC_FILT_MASK 16'h8F7F
`define ASC_SLOT0_RST 16'h8001
`define ASC_SLOT_RST 16'h0001
`define ASC_SLOT_MASK 16'hF3FF
`define ASC_OFFSET_RST 24'h800000
`define ASC_CODE_MSB 24'h800000

// ==========================================================
// field positions
`define ASC_MODE_LSB 4
`define ASC_CLKSEL_LSB 2
`define ASC_SLOT_EN_BIT 15
`define ASC_SLOT_SETUP_LSB 12
`define ASC_SETUP_POL_BIT 12
`define ASC_SETUP_BUF_LSB 8
`define ASC_SETUP_REF_LSB 4

`endif

// file: asc_pkg.sv
// types shared by the register bank modules
// assumes asc_cfg.svh supplies the numeric constants
package asc_pkg;

  typedef enum logic [2:0] {
    ASC_CONTINUOUS = 3'b000,
    ASC_SINGLE = 3'b001,
    ASC_STANDBY = 3'b010,
    ASC_POWER_DOWN = 3'b011,
    ASC_INT_OFFSET_CAL = 3'b100,
    ASC_SYS_OFFSET_CAL = 3'b110,
    ASC_SYS_GAIN_CAL = 3'b111
  } asc_conv_mode_t;

  typedef logic [15:0] asc_word_t;
  typedef logic [23:0] asc_coef_t;

endpackage : asc_pkg

// file: asc_seq_if.sv
// slot sequencer carrier between the bank and its sequencer
// assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface asc_seq_if;
  logic [7:0] en;
  logic step;
  logic [2:0] slot;
  modport ctl (output en, output step, input slot);
  modport seq (input en, input step, output slot);
endinterface : asc_seq_if
`default_nettype wire

// file: asc_slot_seq.sv
// channel slot sequencer: steps through enabled slots
// assumes step is a one-cycle pulse on ref_clk
`timescale 1ns/1ps
`default_nettype none
module asc_slot_seq (
  input wire logic ref_clk,
  input wire logic reset,
  asc_seq_if.seq sif
);

  logic [2:0] slot_r;
  logic [2:0] slot_nxt;

  // next enabled slot above cur, else lowest enabled
  function automatic logic [2:0] asc_next_slot(input logic [7:0] en, input logic [2:0] cur);
    logic [2:0] res;
    logic found;
    res = cur;
    found = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      if (en[i] && (3'(i) > cur)) begin
        res = 3'(i);
        found = 1'b1;
      end
    end
    if (!found) begin
      for (int i = 7; i >= 0; i--) begin
        if (en[i]) begin
          res = 3'(i);
        end
      end
    end
    return res;
  endfunction : asc_next_slot

  always_comb begin
    slot_nxt = asc_next_slot(sif.en, slot_r);
  end

  // ==========================================================
  // slot pointer
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      slot_r <= 3'h0;
    end else if (sif.step && (sif.en != 8'h00)) begin
      slot_r <= slot_nxt;
    end
  end

  assign sif.slot = slot_r;

  // ==========================================================
  // checks
  property p_seq_ascend;
    @(posedge ref_clk) disable iff (reset)
    sif.step && (sif.en != 8'h00) |=> sif.en[slot_r] &&
      ((slot_r > $past(slot_r)) || ((sif.en >> $past(slot_r)) & 8'hFE) == 8'h00 ||
      $changed(sif.en));
  endproperty
  a_seq_ascend: assert property (p_seq_ascend) else $error("slot did not advance upward");

  property p_seq_wrap;
    @(posedge ref_clk) disable iff (reset)
    sif.step && (sif.en == 8'h81) && (slot_r == 3'h7) |=> slot_r == 3'h0;
  endproperty
  a_seq_wrap: assert property (p_seq_wrap) else $error("sequencer failed to wrap");

  c_seq_wrap: cover property (@(posedge ref_clk) disable iff (reset)
    sif.step && (slot_nxt < slot_r));

endmodule : asc_slot_seq
`default_nettype wire

// file: asc_coef_mem.sv
// coefficient store: offsets in words 0-7, gains in words 8-15
// assumes one write port and a registered read with bypass data
`timescale 1ns/1ps
`default_nettype none
`include "asc_cfg.svh"
module asc_coef_mem
  import asc_pkg::*;
#(
  parameter asc_coef_t GAIN_TRIM = 24'h555550
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic we,
  input wire logic [3:0] wa,
  input wire asc_coef_t wd,
  input wire logic [3:0] ra,
  input wire logic rd_mem,
  input wire asc_coef_t alt,
  output asc_coef_t q
);

  asc_coef_t mem [16];

  // ==========================================================
  // storage words
  for (genvar g = 0; g < 16; g++) begin : g_word
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        mem[g] <= (g < 8) ? `ASC_OFFSET_RST : GAIN_TRIM;
      end else if (we && (wa == 4'(g))) begin
        mem[g] <= wd;
      end
    end
  end

  // read data leave from this register for every address
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      q <= 24'h000000;
    end else begin
      q <= rd_mem ? mem[ra] : alt;
    end
  end

  // ==========================================================
  // checks
  property p_offset_rst;
    @(posedge ref_clk) disable iff (reset)
    $fell(reset) |-> (mem[0] == `ASC_OFFSET_RST) && (mem[7] == `ASC_OFFSET_RST);
  endproperty
  a_offset_rst: assert property (p_offset_rst) else $error("offset power-on value wrong");

  property p_gain_rst;
    @(posedge ref_clk) disable iff (reset)
    $fell(reset) |-> (mem[8] == GAIN_TRIM) && (mem[15] == GAIN_TRIM);
  endproperty
  a_gain_rst: assert property (p_gain_rst) else $error("gain trim not loaded");

endmodule : asc_coef_mem
`default_nettype wire

// file: asc_reg_bank.sv
// setup and configuration register bank of the converter
// assumes a same-clock register port, calibration and conversion pulses on ref_clk
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "asc_cfg.svh"
module asc_reg_bank
  import asc_pkg::*;
#(
  parameter asc_coef_t GAIN_TRIM = 24'h555550
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [23:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [23:0] rd_data,
  input wire logic cal_done,
  input wire logic [23:0] cal_value,
  input wire logic conv_done,
  input wire logic raw_valid,
  input wire logic [23:0] raw_sample,
  output logic [2:0] conv_mode,
  output logic [1:0] master_clock_source,
  output logic [15:0] serial_interface_mode,
  output logic [2:0] cur_slot,
  output logic cur_slot_valid,
  output logic [2:0] cur_setup,
  output logic [9:0] cur_input_pair,
  output logic cur_bipolar,
  output logic [3:0] cur_buffer_en,
  output logic [1:0] cur_reference_source,
  output logic [15:0] cur_filter_cfg,
  output logic code_valid,
  output logic [23:0] code_out
);

  // ==========================================================
  // storage
  asc_word_t conversion_mode_reg;
  asc_word_t serial_interface_mode_reg;
  asc_word_t channel_slot_reg [8];
  asc_word_t setup_config_reg [8];
  asc_word_t filter_config_reg [8];

  asc_conv_mode_t mode_now;
  logic cal_fire;
  logic cal_gain;
  logic mem_we;
  logic [3:0] mem_wa;
  asc_coef_t mem_wd;
  logic [23:0] rd_alt;
  logic [7:0] slot_en;
  logic [2:0] slot_setup_select;

  asc_seq_if sif ();

  // ==========================================================
  // decode helpers; asc_is_coef serves the write and read paths, asc_in_group the read mux and the checks
  function automatic logic asc_is_coef(input logic [7:0] a);
    return a[7:4] == 4'h3;
  endfunction : asc_is_coef

  function automatic logic asc_in_group(input logic [7:0] a, input logic [7:0] base);
    return a[7:3] == base[7:3];
  endfunction : asc_in_group

  assign mode_now = asc_conv_mode_t'(conversion_mode_reg[`ASC_MODE_LSB +: 3]);

  // calibration results only land while a calibration mode is selected
  assign cal_gain = (mode_now == ASC_SYS_GAIN_CAL);
  assign cal_fire = cal_done && ((mode_now == ASC_INT_OFFSET_CAL) ||
    (mode_now == ASC_SYS_OFFSET_CAL) || cal_gain);

  // ==========================================================
  // coefficient write port; calibration beats a host write in the same cycle
  always_comb begin
    mem_we = 1'b0;
    mem_wa = 4'h0;
    mem_wd = wr_data;
    if (cal_fire) begin
      mem_we = 1'b1;
      mem_wa = {cal_gain, cur_setup};
      mem_wd = cal_value;
    end else if (wr_stb && asc_is_coef(addr)) begin
      mem_we = 1'b1;
      mem_wa = addr[3:0];
    end
  end

  // ==========================================================
  // conversion mode register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      conversion_mode_reg <= `ASC_MODE_RST;
    end else if (cal_fire) begin
      // a finished calibration parks the converter in standby
      conversion_mode_reg[`ASC_MODE_LSB +: 3] <= ASC_STANDBY;
    end else if (wr_stb && (addr == `ASC_ADDR_MODE)) begin
      conversion_mode_reg <= wr_data[15:0] & `ASC_MODE_MASK;
    end
  end

  // ==========================================================
  // interface mode register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      serial_interface_mode_reg <= `ASC_SERIAL_INTERFACE_MODE_REG_RST;
    end else if (wr_stb && (addr == `ASC_ADDR_SERIAL_INTERFACE_MODE_REG)) begin
      serial_interface_mode_reg <= wr_data[15:0] & `ASC_SERIAL_INTERFACE_MODE_REG_MASK;
    end
  end

  // ==========================================================
  // per-setup and per-slot registers
  for (genvar g = 0; g < 8; g++) begin : g_setup
    always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
        setup_config_reg[g] <= `ASC_SETUP_RST;
        filter_config_reg[g] <= `ASC_FILT_RST;
        channel_slot_reg[g] <= (g == 0) ? `ASC_SLOT0_RST : `ASC_SLOT_RST;
      end else if (wr_stb) begin
        if (addr == (`ASC_ADDR_SETUP0 + 8'(g))) begin
          setup_config_reg[g] <= wr_data[15:0] & `ASC_SETUP_MASK;
        end
        if (addr == (`ASC_ADDR_FILT0 + 8'(g))) begin
          filter_config_reg[g] <= wr_data[15:0] & `ASC_FILT_MASK;
        end
        if (addr == (`ASC_ADDR_SLOT0 + 8'(g))) begin
          channel_slot_reg[g] <= wr_data[15:0] & `ASC_SLOT_MASK;
        end
      end
    end
    assign slot_en[g] = channel_slot_reg[g][`ASC_SLOT_EN_BIT];
  end

  // ==========================================================
  // read mux for the non-coefficient registers; unmapped reads give zero
  always_comb begin
    rd_alt = 24'h000000;
    if (addr == `ASC_ADDR_MODE) begin
      rd_alt = {8'h00, conversion_mode_reg};
    end else if (addr == `ASC_ADDR_SERIAL_INTERFACE_MODE_REG) begin
      rd_alt = {8'h00, serial_interface_mode_reg};
    end else if (asc_in_group(addr, `ASC_ADDR_SLOT0)) begin
      rd_alt = {8'h00, channel_slot_reg[addr[2:0]]};
    end else if (asc_in_group(addr, `ASC_ADDR_SETUP0)) begin
      rd_alt = {8'h00, setup_config_reg[addr[2:0]]};
    end else if (asc_in_group(addr, `ASC_ADDR_FILT0)) begin
      rd_alt = {8'h00, filter_config_reg[addr[2:0]]};
    end
  end

  asc_coef_mem #(
    .GAIN_TRIM(GAIN_TRIM)
  ) u_coef (
    .ref_clk(ref_clk),
    .reset(reset),
    .we(mem_we),
    .wa(mem_wa),
    .wd(mem_wd),
    .ra(addr[3:0]),
    .rd_mem(rd_stb && asc_is_coef(addr)),
    .alt(rd_alt),
    .q(rd_data)
  );

  // ==========================================================
  // slot sequencer; only running conversions move it
  assign sif.en = slot_en;
  assign sif.step = conv_done && ((mode_now == ASC_CONTINUOUS) || (mode_now == ASC_SINGLE));

  asc_slot_seq u_seq (
    .ref_clk(ref_clk),
    .reset(reset),
    .sif(sif)
  );

  // any slot may point at any setup, so sharing is free
  assign slot_setup_select = channel_slot_reg[sif.slot][`ASC_SLOT_SETUP_LSB +: 3];

  // ==========================================================
  // settings of the slot under conversion, registered for the datapath
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cur_slot <= 3'h0;
      cur_slot_valid <= 1'b0;
      cur_setup <= 3'h0;
      cur_input_pair <= 10'h000;
      cur_bipolar <= 1'b0;
      cur_buffer_en <= 4'h0;
      cur_reference_source <= 2'h0;
      cur_filter_cfg <= 16'h0000;
    end else begin
      cur_slot <= sif.slot;
      cur_slot_valid <= slot_en[sif.slot];
      cur_setup <= slot_setup_select;
      cur_input_pair <= channel_slot_reg[sif.slot][9:0];
      cur_bipolar <= setup_config_reg[slot_setup_select][`ASC_SETUP_POL_BIT];
      cur_buffer_en <= setup_config_reg[slot_setup_select][`ASC_SETUP_BUF_LSB +: 4];
      cur_reference_source <= setup_config_reg[slot_setup_select][`ASC_SETUP_REF_LSB +: 2];
      cur_filter_cfg <= filter_config_reg[slot_setup_select];
    end
  end

  // ==========================================================
  // mode outputs
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      conv_mode <= 3'h0;
      master_clock_source <= 2'h0;
      serial_interface_mode <= 16'h0000;
    end else begin
      conv_mode <= conversion_mode_reg[`ASC_MODE_LSB +: 3];
      master_clock_source <= conversion_mode_reg[`ASC_CLKSEL_LSB +: 2];
      serial_interface_mode <= serial_interface_mode_reg;
    end
  end

  // ==========================================================
  // output coding: raw is two's complement; unipolar cannot show negatives
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      code_valid <= 1'b0;
      code_out <= 24'h000000;
    end else begin
      code_valid <= raw_valid;
      if (raw_valid) begin
        if (cur_bipolar) begin
          code_out <= raw_sample ^ `ASC_CODE_MSB;
        end else begin
          code_out <= raw_sample[23] ? 24'h000000 : raw_sample;
        end
      end
    end
  end

  // ==========================================================
  // checks
  property p_gain_host_wr;
    @(posedge ref_clk) disable iff (reset)
    (wr_stb && asc_in_group(addr, `ASC_ADDR_GAIN_COEFF_REG0) && !cal_fire)
      ##1 (rd_stb && (addr == $past(addr)) && !cal_fire) |=> rd_data == $past(wr_data, 2);
  endproperty
  a_gain_host_wr: assert property (p_gain_host_wr) else $error("gain write not read back");

  property p_offset_cal;
    @(posedge ref_clk) disable iff (reset)
    cal_done && ((mode_now == ASC_INT_OFFSET_CAL) || (mode_now == ASC_SYS_OFFSET_CAL))
      |-> mem_we && (mem_wa == {1'b0, cur_setup}) && (mem_wd == cal_value);
  endproperty
  a_offset_cal: assert property (p_offset_cal) else $error("zero-scale result not stored");

  property p_gain_cal;
    @(posedge ref_clk) disable iff (reset)
    // register parks one edge later, the mode output one more
    cal_done && cal_gain |-> mem_we && mem_wa[3] ##2 (conv_mode == ASC_STANDBY);
  endproperty
  a_gain_cal: assert property (p_gain_cal) else $error("full-scale result not stored");

  property p_mode_wr;
    @(posedge ref_clk) disable iff (reset)
    wr_stb && (addr == `ASC_ADDR_MODE) && !cal_fire
      |=> ##1 conv_mode == $past(wr_data[6:4], 2);
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode output not following write");

  property p_serial_interface_mode_reg_rst;
    @(posedge ref_clk) disable iff (reset)
    $fell(reset) |-> (serial_interface_mode_reg == 16'h0000) ##1 (serial_interface_mode == 16'h0000);
  endproperty
  a_serial_interface_mode_reg_rst: assert property (p_serial_interface_mode_reg_rst) else $error("interface mode reset wrong");

  property p_setup0_rst;
    @(posedge ref_clk) disable iff (reset)
    $fell(reset) |-> (setup_config_reg[0] == 16'h1000) && (setup_config_reg[0][5:4] == 2'b00);
  endproperty
  a_setup0_rst: assert property (p_setup0_rst) else $error("setup 0 reset wrong");

  property p_reserved;
    @(posedge ref_clk) disable iff (reset)
    wr_stb && asc_in_group(addr, `ASC_ADDR_SETUP0) |=>
      (setup_config_reg[$past(addr[2:0])] & ~`ASC_SETUP_MASK) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved setup bits stored");

  property p_cur_setup;
    @(posedge ref_clk) disable iff (reset)
    // outputs still in reset on the release edge
    !$past(reset) |=> (cur_setup == $past(slot_setup_select)) &&
      (cur_slot_valid == $past(slot_en[sif.slot]));
  endproperty
  a_cur_setup: assert property (p_cur_setup) else $error("slot setup mapping wrong");

  property p_bipolar_code;
    @(posedge ref_clk) disable iff (reset)
    raw_valid && cur_bipolar |=> code_valid && (code_out == ($past(raw_sample) ^ 24'h800000));
  endproperty
  a_bipolar_code: assert property (p_bipolar_code) else $error("offset binary coding wrong");

  c_offset_cal: cover property (@(posedge ref_clk) disable iff (reset)
    cal_fire && !cal_gain);
  c_gain_rw: cover property (@(posedge ref_clk) disable iff (reset)
    (wr_stb && asc_in_group(addr, `ASC_ADDR_GAIN_COEFF_REG0)) ##1 rd_stb);
  c_shared_setup: cover property (@(posedge ref_clk) disable iff (reset)
    sif.step && (slot_en[1:0] == 2'b11) &&
    (channel_slot_reg[0][14:12] == channel_slot_reg[1][14:12]));

endmodule : asc_reg_bank
`default_nettype wire

// file: asc_host_model.sv
// host-side register port model, one access per task call
// assumes the bench calls its tasks; one clock, no wait states
`timescale 1ns/1ps
`default_nettype none
module asc_host_model (
  input wire logic ref_clk,
  output logic [7:0] addr,
  output logic [23:0] wr_data,
  output logic wr_stb,
  output logic rd_stb
);
  // ==========================================================
  // bus cycles
  initial begin
    addr = 8'h00;
    wr_data = 24'h000000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    wr_data <= ~wr_data;
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
  endtask : rd

  // released lines toggle so stale values never look valid
  task automatic idle();
    @(posedge ref_clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    wr_data <= ~wr_data;
    addr <= ~addr;
  endtask : idle
endmodule : asc_host_model
`default_nettype wire

// file: tb_top.sv
// self-checking bench of the register bank
// assumes asc_host_model drives the register port
`timescale 1ns/1ps
`default_nettype none
`include "asc_cfg.svh"
module tb_top import asc_pkg::*;;
  localparam asc_coef_t TRIM = 24'h5A5A50; // arbitrary trim value
  logic ref_clk, reset, wr_stb, rd_stb, cal_done, conv_done, raw_valid;
  logic code_valid, cur_slot_valid, cur_bipolar;
  logic [7:0] addr;
  logic [23:0] wr_data, rd_data, cal_value, raw_sample, code_out, v, sl, sc;
  logic [2:0] conv_mode, cur_slot, cur_setup, st;
  logic [1:0] master_clock_source, cur_reference_source;
  logic [15:0] serial_interface_mode, cur_filter_cfg;
  logic [9:0] cur_input_pair;
  logic [3:0] cur_buffer_en;
  logic [23:0] mir [256];
  logic [23:0] exp_rd [$];
  logic [23:0] exp_code [$];
  logic rd_d1 = 1'b0;
  int error_cnt, num_checks;
  integer seed = 32'h59a7b6d9;
  int seq_exp [4] = '{2, 5, 0, 2};
  int cm [3] = '{4, 6, 7};

  asc_reg_bank #(.GAIN_TRIM(TRIM)) dut (.ref_clk, .reset, .addr, .wr_data, .wr_stb,
    .rd_stb, .rd_data, .cal_done, .cal_value, .conv_done, .raw_valid, .raw_sample,
    .conv_mode, .master_clock_source, .serial_interface_mode, .cur_slot,
    .cur_slot_valid, .cur_setup, .cur_input_pair, .cur_bipolar, .cur_buffer_en,
    .cur_reference_source, .cur_filter_cfg, .code_valid, .code_out);
  asc_host_model host (.ref_clk, .addr, .wr_data, .wr_stb, .rd_stb);

  // ==========================================================
  // helpers
  function automatic logic [23:0] msk(input logic [7:0] a);
    if (a == `ASC_ADDR_MODE) return {8'h00, `ASC_MODE_MASK};
    if (a == `ASC_ADDR_SERIAL_INTERFACE_MODE_REG) return {8'h00, `ASC_SERIAL_INTERFACE_MODE_REG_MASK};
    if (a[7:3] == 5'h02) return {8'h00, `ASC_SLOT_MASK};
    if (a[7:3] == 5'h04) return {8'h00, `ASC_SETUP_MASK};
    if (a[7:3] == 5'h05) return {8'h00, `ASC_FILT_MASK};
    if (a[7:4] == 4'h3) return 24'hFFFFFF;
    return 24'h000000;
  endfunction : msk

  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic close_out();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    host.wr(a, d);
    mir[a] = d & msk(a);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    host.rd(a);
    exp_rd.push_back(mir[a]);
  endtask : rd

  task automatic settle(input int n);
    host.idle();
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : settle

  task automatic pulse_conv();
    @(posedge ref_clk) conv_done <= 1'b1;
    @(posedge ref_clk) conv_done <= 1'b0;
  endtask : pulse_conv

  task automatic cal(input logic [23:0] d);
    @(posedge ref_clk);
    cal_done <= 1'b1;
    cal_value <= d;
    @(posedge ref_clk);
    cal_done <= 1'b0;
    cal_value <= ~d;
  endtask : cal

  task automatic raw(input logic [23:0] d, input logic bip);
    @(posedge ref_clk);
    raw_valid <= 1'b1;
    raw_sample <= d;
    exp_code.push_back(bip ? d ^ `ASC_CODE_MSB : (d[23] ? 24'h000000 : d));
    @(posedge ref_clk);
    raw_valid <= 1'b0;
    raw_sample <= ~d;
  endtask : raw

  task automatic step(input int s);
    pulse_conv();
    settle(1);
    sl = mir[8'h10 + s];
    st = sl[14:12];
    sc = mir[8'h20 + st];
    check("cur_slot", 24'(cur_slot), 24'(s));
    check("cur_slot_valid", 24'(cur_slot_valid), 24'h1);
    check("cur_setup", 24'(cur_setup), 24'(st));
    check("cur_input_pair", 24'(cur_input_pair), 24'(sl[9:0]));
    check("cur_reference_source", 24'(cur_reference_source), 24'(sc[5:4]));
    check("cur_bipolar", 24'(cur_bipolar), 24'(sc[12]));
    check("cur_buffer_en", 24'(cur_buffer_en), 24'(sc[11:8]));
    check("cur_filter_cfg", 24'(cur_filter_cfg), mir[8'h28 + st] & 24'h00FFFF);
  endtask : step

  // ==========================================================
  // clock, monitor, watchdog
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    rd_d1 <= rd_stb;
    // read data stand only in the cycle after the strobe
    if (rd_d1) check("rd_data", rd_data, exp_rd.pop_front());
    if (code_valid === 1'b1) check("code_out", code_out, exp_code.pop_front());
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    close_out();
  end

  // ==========================================================
  // scenarios
  initial begin
    reset = 1'b1;
    {cal_done, conv_done, raw_valid} = 3'b000;
    {cal_value, raw_sample} = 48'h0;
    for (int i = 0; i < 256; i++) mir[i] = 24'h000000;
    mir[1] = {8'h00, `ASC_MODE_RST};
    for (int i = 0; i < 8; i++) begin
      mir[8'h10 + i] = (i == 0) ? {8'h00, `ASC_SLOT0_RST} : {8'h00, `ASC_SLOT_RST};
      mir[8'h20 + i] = 24'h001000;
      mir[8'h28 + i] = {8'h00, `ASC_FILT_RST};
      mir[8'h30 + i] = 24'h800000;
      mir[8'h38 + i] = TRIM;
    end
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    settle(1);
    // reset mode word leaves the mode field at continuous
    check("conv_mode", 24'(conv_mode), 24'h0);
    check("cur_reference_source", 24'(cur_reference_source), 24'h0);
    check("serial_interface_mode", 24'(serial_interface_mode), 24'h0);
    // coefficients untouched, conversion output still produced
    raw(24'($random(seed)), 1'b1);
    for (int a = 0; a <= 8'h40; a++) rd(8'(a));
    rd(8'hFF);
    for (int a = 0; a <= 8'h40; a++) if (a != 1) wr(8'(a), 24'($random(seed)));
    for (int a = 0; a <= 8'h40; a++) rd(8'(a));
    settle(1);
    check("serial_interface_mode", 24'(serial_interface_mode), mir[2]);
    for (int s = 0; s < 8; s++) begin
      v = (s == 0) ? 24'h00B012 : (s == 2) ? 24'h00D034 : (s == 5) ? 24'h009056 : 24'h0;
      wr(8'(8'h10 + s), v);
    end
    wr(`ASC_ADDR_MODE, 24'h000008);
    settle(1);
    check("conv_mode", 24'(conv_mode), 24'h0);
    check("master_clock_source", 24'(master_clock_source), 24'h2);
    foreach (seq_exp[k]) step(seq_exp[k]);
    for (int i = 0; i < 4; i++) begin
      if (i == 0 || i == 2) begin
        wr(8'h25, (i == 0) ? 24'h001000 : 24'h000010);
        settle(2);
      end
      v = 24'($random(seed));
      v[23] = i[0];
      raw(v, i < 2);
    end
    foreach (cm[i]) begin
      wr(`ASC_ADDR_MODE, 24'(cm[i] << 4));
      host.idle();
      v = 24'($random(seed));
      cal(v);
      mir[(cm[i] == 7) ? 8'h3D : 8'h35] = v;
      mir[1][6:4] = 3'd2;
      settle(1);
      check("conv_mode", 24'(conv_mode), 24'h2);
      rd((cm[i] == 7) ? 8'h3D : 8'h35);
      rd(`ASC_ADDR_MODE);
    end
    // standby must not advance the sequencer
    host.idle();
    pulse_conv();
    settle(1);
    check("cur_slot", 24'(cur_slot), 24'h2);
    wr(`ASC_ADDR_MODE, 24'h000000);
    host.idle();
    cal(24'($random(seed)));
    rd(8'h35);
    rd(8'h3D);
    wr(8'h3A, 24'($random(seed)));
    rd(8'h3A);
    settle(4);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
